// ==== sff_front_end.sv ====
`timescale 1ns/1ps
module sff_front_end
    import sff_pkg::*;
#(
    parameter int unsigned PUW_CYCLES = PUW_CYCLES_DEF
)
(
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // Serial link pins
    input wire logic serial_clk,
    input wire logic select_n,
    input wire logic [3:0] lane_in,
    output logic [3:0] lane_out,
    output logic [3:0] lane_oe,
    // Array engine side
    output logic op_start,
    output logic [7:0] op_code,
    output logic [23:0] op_addr,
    output logic data_strobe,
    output logic [7:0] data_byte,
    input wire logic op_done,
    input wire logic [7:0] array_rdata,
    // Status view
    output logic [15:0] status_word,
    output logic paused,
    output logic power_down
);
    // ***********************************************
    // Pin sampling
    // ***********************************************
    logic [5:0] pins_s;
    logic sel_s, sclk_s, sel_on, rise_ok, fall_ok, cs_fall, cs_rise;
    logic [3:0] lanes_s;
    logic sclk_prev_reg, sel_prev_reg;

    sff_sync #(.W(6)) u_sync (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .d({select_n, serial_clk, lane_in}),
        .q(pins_s)
    );

    assign sel_s = pins_s[5];
    assign sclk_s = pins_s[4];
    assign lanes_s = pins_s[3:0];
    assign sel_on = !sel_s;
    assign cs_fall = sel_prev_reg && !sel_s;
    assign cs_rise = !sel_prev_reg && sel_s;

    // ***********************************************
    // State
    // ***********************************************
    sff_state_type state_reg, state_next;
    logic [4:0] cnt_reg, cnt_next;
    logic [7:0] cmd_reg, cmd_next, sin_reg, sin_next, sout_reg, sout_next, cur;
    logic [3:0] rem_reg, rem_next;
    logic [15:0] status_reg, status_next, wrsr_reg, wrsr_next, wr_mask;
    logic [1:0] nbytes_reg, nbytes_next;
    logic [PUW_W-1:0] puw_reg, puw_next;
    logic armed_reg, armed_next, pd_reg, pd_next, paused_reg, paused_next;
    logic [3:0] lane_out_reg, lane_out_next, lane_oe_reg, lane_oe_next, oe_mask;
    logic op_start_reg, op_start_next, strobe_reg, strobe_next;
    logic [7:0] op_code_reg, op_code_next, dbyte_reg, dbyte_next, cmd_full, src_byte;
    logic [23:0] op_addr_reg, op_addr_next;

    // ***********************************************
    // Decoding
    // ***********************************************
    logic quad_en, busy, wpl, pause_req, puw_active, reject, rd_status, lock_ok, chip_free, arr_ok;
    logic [2:0] aw, dw;

    assign quad_en = status_reg[SB_QUAD];
    assign busy = status_reg[SB_BUSY];
    assign wpl = status_reg[SB_WPL];
    assign puw_active = puw_reg != '0;
    assign puw_next = puw_active ? puw_reg - 1'b1 : puw_reg;
    assign armed_next = armed_reg || sel_s;
    // Lane 3 is data with four lanes; the pins clear low at reset, so no pause until select was seen high.
    assign pause_req = sel_on && armed_reg && !quad_en && !lanes_s[3] && !sff_is_quad(cmd_reg);
    // Entering and leaving wait for a low clock, at once if it is already low; a deselect ends a pause without waiting.
    assign paused_next = !sel_on ? 1'b0 : ((pause_req != paused_reg && !sclk_s) ? pause_req : paused_reg);
    assign rise_ok = sclk_s && !sclk_prev_reg && !paused_reg && sel_on;
    assign fall_ok = !sclk_s && sclk_prev_reg && !paused_reg && sel_on;
    assign cmd_full = {sin_reg[6:0], lanes_s[0]};
    assign aw = sff_addr_lanes(cmd_reg);
    assign dw = sff_data_lanes(cmd_reg);
    assign rd_status = cmd_reg == CMD_RDSR1 || cmd_reg == CMD_RDSR2;
    assign src_byte = rd_status ? ((cmd_reg == CMD_RDSR2) ? status_reg[15:8] : status_reg[7:0]) : array_rdata;
    assign cur = (rem_reg == 4'h0) ? src_byte : sout_reg;
    assign oe_mask = (dw == 3'h4) ? 4'hF : ((dw == 3'h2) ? 4'h3 : 4'h2);
    assign reject = (pd_reg && cmd_full != CMD_PDREL)
        || (busy && cmd_full != CMD_RDSR1 && cmd_full != CMD_RDSR2 && cmd_full != CMD_SUSP)
        || (puw_active && (sff_is_alter(cmd_full) || cmd_full == CMD_WREN))
        || (sff_is_alter(cmd_full) && !wpl)
        || (sff_is_quad(cmd_full) && !quad_en);
    // A low guard pin only counts while lane 2 is not a data lane.
    assign lock_ok = wpl && !status_reg[SB_LOCK1] && !(status_reg[SB_LOCK0] && !lanes_s[2] && !quad_en);
    assign chip_free = !sff_guarded(20'h00000, status_reg) && !sff_guarded(20'hFFFFF, status_reg);
    assign arr_ok = (cmd_reg == CMD_CE1 || cmd_reg == CMD_CE2) ? chip_free
        : !sff_guarded(op_addr_reg[19:0], status_reg);
    assign wr_mask = (nbytes_reg > 2'h1) ? WR_MASK : (WR_MASK & LOW_MASK);

    // ***********************************************
    // Next state
    // ***********************************************
    always_comb
    begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        cmd_next = cmd_reg;
        sin_next = sin_reg;
        sout_next = sout_reg;
        rem_next = rem_reg;
        status_next = status_reg;
        wrsr_next = wrsr_reg;
        nbytes_next = nbytes_reg;
        pd_next = pd_reg;
        lane_out_next = lane_out_reg;
        op_start_next = 1'b0;
        op_code_next = op_code_reg;
        op_addr_next = op_addr_reg;
        strobe_next = 1'b0;
        dbyte_next = dbyte_reg;
        if (op_done && busy)
        begin
            status_next[SB_BUSY] = 1'b0;
            status_next[SB_WPL] = 1'b0;
        end
        if (!sel_on)
        begin
            // A select rise before a whole byte drops the instruction; a pause alone does not.
            state_next = ST_IDLE;
            cnt_next = 5'h00;
            if (cs_rise && state_reg == ST_DIN && cnt_reg == 5'h00)
            begin
                if (cmd_reg == CMD_WREN)
                    status_next[SB_WPL] = 1'b1;
                else if (cmd_reg == CMD_WRDI)
                    status_next[SB_WPL] = 1'b0;
                else if (cmd_reg == CMD_PDOWN)
                    pd_next = 1'b1;
                else if (cmd_reg == CMD_PDREL)
                    pd_next = 1'b0;
                else if (cmd_reg == CMD_WRSR && nbytes_reg != 2'h0 && lock_ok)
                begin
                    // Bits 13:10 are one-time: a write can set them but never clear them.
                    status_next = (status_reg & ~wr_mask) | (wrsr_reg & wr_mask) | (status_reg & OTP_MASK);
                    status_next[SB_BUSY] = 1'b1;
                    op_start_next = 1'b1;
                    op_code_next = cmd_reg;
                end
                else if (sff_is_alter(cmd_reg) && cmd_reg != CMD_WRSR && wpl && arr_ok
                    && ((cmd_reg == CMD_PROG) == (nbytes_reg != 2'h0)))
                begin
                    status_next[SB_BUSY] = 1'b1;
                    op_start_next = 1'b1;
                    op_code_next = cmd_reg;
                end
            end
        end
        else
        begin
            unique case (state_reg)
                ST_IDLE:
                    // Only a select fall starts an instruction, so the idle clock level is free.
                    if (cs_fall && armed_reg)
                    begin
                        state_next = ST_CMD;
                        cnt_next = 5'h00;
                        nbytes_next = 2'h0;
                    end
                ST_CMD:
                    if (rise_ok)
                    begin
                        sin_next = cmd_full;
                        cnt_next = cnt_reg + 5'h01;
                        if (cnt_reg == 5'h07)
                        begin
                            cmd_next = cmd_full;
                            state_next = reject ? ST_SKIP : sff_after_cmd(cmd_full);
                            cnt_next = 5'h00;
                            rem_next = 4'h0;
                        end
                    end
                ST_ADDR:
                    if (rise_ok)
                    begin
                        op_addr_next = (aw == 3'h4) ? {op_addr_reg[19:0], lanes_s}
                            : ((aw == 3'h2) ? {op_addr_reg[21:0], lanes_s[1:0]}
                            : {op_addr_reg[22:0], lanes_s[0]});
                        cnt_next = cnt_reg + {2'h0, aw};
                        if (cnt_reg + {2'h0, aw} == ADDR_BITS)
                        begin
                            cnt_next = 5'h00;
                            state_next = sff_is_alter(cmd_reg) ? ST_DIN
                                : ((sff_dummy(cmd_reg) != 5'h00) ? ST_DUMMY : ST_DOUT);
                        end
                    end
                ST_DUMMY:
                    if (rise_ok)
                    begin
                        cnt_next = cnt_reg + 5'h01;
                        if (cnt_reg + 5'h01 == sff_dummy(cmd_reg))
                        begin
                            cnt_next = 5'h00;
                            state_next = ST_DOUT;
                        end
                    end
                ST_DIN:
                    if (rise_ok)
                    begin
                        sin_next = cmd_full;
                        cnt_next = (cnt_reg == 5'h07) ? 5'h00 : cnt_reg + 5'h01;
                        if (cnt_reg == 5'h07)
                        begin
                            nbytes_next = (nbytes_reg == 2'h3) ? nbytes_reg : nbytes_reg + 2'h1;
                            if (cmd_reg == CMD_PROG)
                            begin
                                strobe_next = 1'b1;
                                dbyte_next = cmd_full;
                            end
                            if (nbytes_reg == 2'h0)
                                wrsr_next[7:0] = cmd_full;
                            else if (nbytes_reg == 2'h1)
                                wrsr_next[15:8] = cmd_full;
                        end
                    end
                ST_DOUT:
                    if (fall_ok)
                    begin
                        // Status repeats for as long as the host clocks.
                        lane_out_next = (dw == 3'h4) ? cur[7:4]
                            : ((dw == 3'h2) ? {2'h0, cur[7:6]} : {2'h0, cur[7], 1'b0});
                        sout_next = cur << dw;
                        rem_next = ((rem_reg == 4'h0) ? 4'h8 : rem_reg) - {1'b0, dw};
                        cnt_next = 5'h01;
                        if (rem_reg == 4'h0 && !rd_status)
                        begin
                            strobe_next = 1'b1;
                            dbyte_next = array_rdata;
                            op_addr_next = op_addr_reg + 24'h000001;
                        end
                    end
                ST_SKIP:
                    state_next = ST_SKIP;
                default:
                    state_next = ST_IDLE;
            endcase
        end
        // Pins float while paused, deselected or receiving.
        lane_oe_next = (state_next == ST_DOUT && cnt_next != 5'h00 && !paused_next) ? oe_mask : 4'h0;
    end

    // ***********************************************
    // Registers
    // ***********************************************
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            state_reg <= ST_IDLE;
            cnt_reg <= '0;
            cmd_reg <= '0;
            sin_reg <= '0;
            sout_reg <= '0;
            rem_reg <= '0;
            status_reg <= STATUS_RESET;
            wrsr_reg <= '0;
            nbytes_reg <= '0;
            puw_reg <= PUW_W'(PUW_CYCLES);
            armed_reg <= 1'b0;
            pd_reg <= 1'b0;
            paused_reg <= 1'b0;
            lane_out_reg <= '0;
            lane_oe_reg <= '0;
            op_start_reg <= 1'b0;
            op_code_reg <= '0;
            op_addr_reg <= '0;
            strobe_reg <= 1'b0;
            dbyte_reg <= '0;
            sclk_prev_reg <= 1'b0;
            sel_prev_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            cmd_reg <= cmd_next;
            sin_reg <= sin_next;
            sout_reg <= sout_next;
            rem_reg <= rem_next;
            status_reg <= status_next;
            wrsr_reg <= wrsr_next;
            nbytes_reg <= nbytes_next;
            puw_reg <= puw_next;
            armed_reg <= armed_next;
            pd_reg <= pd_next;
            paused_reg <= paused_next;
            lane_out_reg <= lane_out_next;
            lane_oe_reg <= lane_oe_next;
            op_start_reg <= op_start_next;
            op_code_reg <= op_code_next;
            op_addr_reg <= op_addr_next;
            strobe_reg <= strobe_next;
            dbyte_reg <= dbyte_next;
            sclk_prev_reg <= sclk_s;
            sel_prev_reg <= sel_s;
        end
    end

    assign lane_out = lane_out_reg;
    assign lane_oe = lane_oe_reg;
    assign op_start = op_start_reg;
    assign op_code = op_code_reg;
    assign op_addr = op_addr_reg;
    assign data_strobe = strobe_reg;
    assign data_byte = dbyte_reg;
    assign status_word = status_reg;
    assign paused = paused_reg;
    assign power_down = pd_reg;

    // ***********************************************
    // Checks
    // ***********************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    deselect_float_a: assert property (sel_s |=> lane_oe_reg == 4'h0)
        else $error("lanes driven while deselected");
    pause_float_a: assert property (paused_reg |-> lane_oe_reg == 4'h0)
        else $error("lanes driven while paused");
    pause_freeze_a: assert property (paused_reg && !sel_s |=> $stable(cnt_reg) && $stable(op_addr_reg))
        else $error("state moved while paused");
    quad_lane_a: assert property (lane_oe_reg[3] |-> quad_en && !paused_reg)
        else $error("lane 3 driven without four lanes");
    start_busy_a: assert property (op_start_reg |-> busy && !$past(busy))
        else $error("start without busy rise");
    done_clear_a: assert property (busy && op_done |=> !busy && !wpl)
        else $error("completion left busy or latch");
    puw_block_a: assert property (puw_active |=> !$rose(wpl) && !op_start_reg)
        else $error("alter accepted in power-up delay");
    status_lock_a: assert property ($changed(status_reg[14:2]) |-> $past(wpl) && !$past(status_reg[SB_LOCK1]))
        else $error("status written while locked");
    pd_ignore_a: assert property (pd_reg && state_reg == ST_CMD && rise_ok && cnt_reg == 5'h07
        && cmd_full != CMD_PDREL |=> state_reg == ST_SKIP)
        else $error("instruction taken in power-down");
    cmd_capture_a: assert property (state_reg == ST_CMD && rise_ok && cnt_reg == 5'h07
        |=> cmd_reg == $past(cmd_full))
        else $error("instruction byte misassembled");

    status_read_c: cover property (state_reg == ST_DOUT && rd_status && fall_ok);
    quad_read_c: cover property (lane_oe_reg == 4'hF);
    pause_c: cover property ($rose(paused_reg) ##[1:200] $fell(paused_reg));
    status_write_c: cover property (op_start_reg && op_code_reg == CMD_WRSR);
endmodule // sff_front_end

// ==== sff_front_end_tb.sv ====
`timescale 1ns/1ps
module sff_front_end_tb;
    import sff_pkg::*;
    logic mclk, sys_rst, sclk, sel_n, op_done, op_start, data_strobe, paused, power_down;
    logic [3:0] drv, pin, lane_out, lane_oe;
    logic [7:0] op_code, data_byte, rx, rg, dly;
    logic [23:0] op_addr, ad;
    logic [15:0] status_word;
    logic [7:0] exp_q[$];
    int err_total, num_checks, ps, pz = 0;
    assign pin = (lane_oe & lane_out) | (~lane_oe & drv);
    assign op_done = dly[7];
    sff_front_end #(.PUW_CYCLES(300)) uut (.mclk(mclk), .sys_rst(sys_rst), .serial_clk(sclk), .select_n(sel_n),
        .lane_in(pin), .lane_out(lane_out), .lane_oe(lane_oe), .op_start(op_start), .op_code(op_code),
        .op_addr(op_addr), .data_strobe(data_strobe), .data_byte(data_byte), .op_done(op_done),
        .array_rdata(op_addr[7:0] ^ 8'h5A), .status_word(status_word), .paused(paused), .power_down(power_down));
    sff_host_model hm (.mclk(mclk), .sclk(sclk), .sel_n(sel_n), .drv(drv), .pin(pin));
    initial
    begin
        mclk = 1'b0;
        dly = 8'h00;
        forever #50 mclk = ~mclk;
    end
    // The engine answers each start eight cycles later.
    always @(posedge mclk)
    begin
        dly <= {dly[6:0], op_start === 1'b1};
        pz <= pz + ((paused === 1'b1) ? 1 : 0);
        if (op_start === 1'b1)
            chk("op_code", (exp_q.size() != 0) ? exp_q.pop_front() : 8'h00, op_code);
    end
    task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] s);
        num_checks++;
        if (s !== e)
        begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic st(input logic [7:0] e, input int n);
        hm.xfer({CMD_RDSR1, 40'h0}, 16, rx);
        chk("status read", e, rx);
        chk("status_word", e, status_word[7:0]);
        $display("test %0d done", n);
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial
    begin
        #2_000_000;
        err_total++;
        wrap_up;
    end
    initial
    begin
        err_total = 0;
        num_checks = 0;
        sys_rst = 1'b1;
        void'($urandom(14767));
        repeat (8) @(posedge mclk);
        sys_rst <= 1'b0;
        repeat (4) @(posedge mclk);
        hm.xfer({CMD_WREN, 40'h0}, 8, rx);
        st(8'h00, 1);
        repeat (300) @(posedge mclk);
        hm.xfer({CMD_WRSR, 8'h1C, 32'h0}, 16, rx);
        st(8'h00, 2);
        hm.xfer({CMD_WREN, 40'h0}, 8, rx);
        st(8'h02, 3);
        rg = 8'($urandom) & 8'h7C;
        exp_q.push_back(CMD_WRSR);
        hm.xfer({CMD_WRSR, rg, 32'h0}, 16, rx);
        st(rg, 4);
        ad = 24'($urandom) & 24'h0FFFFF;
        hm.xfer({CMD_FREAD, ad, 16'h0}, 48, rx);
        chk("read byte", ad[7:0] ^ 8'h5A, rx);
        hm.xfer({CMD_PDOWN, 40'h0}, 8, rx);
        chk("power_down", 1'b1, power_down);
        hm.xfer({CMD_WREN, 40'h0}, 8, rx);
        hm.xfer({CMD_PDREL, 40'h0}, 8, rx);
        chk("power_down", 1'b0, power_down);
        st(rg, 5);
        ps = pz;
        hm.hold_at = 11;
        st(rg, 6);
        chk("paused", 1'b1, pz > ps);
        hm.hold_at = -1;
        hm.cpol = 1'b1;
        st(rg, 7);
        hm.cpol = 1'b0;
        ad = 24'($urandom) & 24'h0FFFFF;
        hm.w = 2;
        hm.xfer({CMD_DOUT2, ad, 16'h0}, 44, rx);
        chk("dual byte", ad[7:0] ^ 8'h5A, rx);
        hm.w = 1;
        hm.xfer({CMD_WREN, 40'h0}, 8, rx);
        exp_q.push_back(CMD_WRSR);
        hm.xfer({CMD_WRSR, 16'h0002, 24'h0}, 24, rx);
        st(8'h00, 8);
        chk("status_word", 16'h0200, status_word);
        hm.w = 4;
        hm.xfer({CMD_QOUT, ad, 16'h0}, 42, rx);
        chk("quad byte", ad[7:0] ^ 8'h5A, rx);
        hm.w = 1;
        hm.xfer({CMD_WREN, 40'h0}, 8, rx);
        exp_q.push_back(CMD_PROG);
        hm.xfer({CMD_PROG, ad, rg, 8'h0}, 40, rx);
        chk("data_byte", rg, data_byte);
        chk("op_addr", ad, op_addr);
        chk("pending starts", 24'h0, 24'(exp_q.size()));
        $display("test 9 done");
        wrap_up;
    end
endmodule // sff_front_end_tb

// ==== sff_host_model.sv ====
`timescale 1ns/1ps
module sff_host_model
(
    // Clock
    input wire logic mclk,
    // Link pins
    output logic sclk,
    output logic sel_n,
    output logic [3:0] drv,
    input wire logic [3:0] pin
);
    // Lanes read per clock, idle clock level (high for mode 3) and the bit before which a pause is made.
    int w = 1;
    logic cpol = 1'b0;
    int hold_at = -1;
    initial
    begin
        sclk = 1'b0;
        sel_n = 1'b1;
        drv = 4'hF;
    end
    // Four mclk per half period. Lane 1 toggles while released so a stale level never reads true.
    task automatic xfer(input logic [47:0] tx, input int n, output logic [7:0] rx);
        sclk <= cpol;
        repeat (2) @(posedge mclk);
        sel_n <= 1'b0;
        repeat (4) @(posedge mclk);
        for (int i = 0; i < n; i++)
        begin
            if (i == hold_at)
            begin
                // Pause raised with the clock high, so it only starts at the following fall.
                drv[3] <= 1'b0;
                repeat (2) @(posedge mclk);
                sclk <= 1'b0;
                repeat (6) @(posedge mclk);
                drv[3] <= 1'b1;
                repeat (4) @(posedge mclk);
            end
            drv <= {2'h3, ~drv[1], tx[47-i]};
            sclk <= 1'b0;
            repeat (4) @(posedge mclk);
            rx = (w == 4) ? {rx[3:0], pin} : ((w == 2) ? {rx[5:0], pin[1:0]} : {rx[6:0], pin[1]});
            sclk <= 1'b1;
            repeat (4) @(posedge mclk);
        end
        sclk <= cpol;
        repeat (4) @(posedge mclk);
        sel_n <= 1'b1;
        repeat (12) @(posedge mclk);
    endtask
endmodule // sff_host_model

// ==== sff_pkg.sv ====
package sff_pkg;
    localparam logic [7:0] CMD_WREN = 8'h06;
    localparam logic [7:0] CMD_WRDI = 8'h04;
    localparam logic [7:0] CMD_RDSR1 = 8'h05;
    localparam logic [7:0] CMD_RDSR2 = 8'h35;
    localparam logic [7:0] CMD_WRSR = 8'h01;
    localparam logic [7:0] CMD_READ = 8'h03;
    localparam logic [7:0] CMD_FREAD = 8'h0B;
    localparam logic [7:0] CMD_DOUT2 = 8'h3B;
    localparam logic [7:0] CMD_DIO2 = 8'hBB;
    localparam logic [7:0] CMD_QOUT = 8'h6B;
    localparam logic [7:0] CMD_QIO = 8'hEB;
    localparam logic [7:0] CMD_QWORD = 8'hE7;
    localparam logic [7:0] CMD_QOCT = 8'hE3;
    localparam logic [7:0] CMD_PROG = 8'h02;
    localparam logic [7:0] CMD_SE = 8'h20;
    localparam logic [7:0] CMD_BE32 = 8'h52;
    localparam logic [7:0] CMD_BE64 = 8'hD8;
    localparam logic [7:0] CMD_CE1 = 8'hC7;
    localparam logic [7:0] CMD_CE2 = 8'h60;
    localparam logic [7:0] CMD_PDOWN = 8'hB9;
    localparam logic [7:0] CMD_PDREL = 8'hAB;
    localparam logic [7:0] CMD_SUSP = 8'h75;
    localparam int SB_BUSY = 0;
    localparam int SB_WPL = 1;
    localparam int SB_RG_LO = 2;
    localparam int SB_LOWEND = 5;
    localparam int SB_SMALL = 6;
    localparam int SB_LOCK0 = 7;
    localparam int SB_LOCK1 = 8;
    localparam int SB_QUAD = 9;
    localparam int SB_INV = 14;
    localparam logic [15:0] STATUS_RESET = 16'h0000;
    localparam logic [15:0] WR_MASK = 16'h7FFC;
    localparam logic [15:0] LOW_MASK = 16'h00FF;
    localparam logic [15:0] OTP_MASK = 16'h3C00;
    localparam logic [4:0] ADDR_BITS = 5'h18;
    localparam logic [20:0] ARRAY_SIZE = 21'h100000;
    localparam logic [20:0] BLOCK_SIZE = 21'h010000;
    localparam logic [20:0] SECTOR_SIZE = 21'h001000;
    localparam logic [20:0] SMALL_MAX = 21'h008000;
    localparam int MCLK_HZ = 10_000_000;
    localparam int PUW_TIME_US = 10_000;
    localparam int PUW_CYCLES_DEF = PUW_TIME_US * (MCLK_HZ / 1_000_000);
    localparam int PUW_W = 17;

    typedef enum logic [6:0] {
        ST_IDLE = 7'h01, ST_CMD = 7'h02, ST_ADDR = 7'h04, ST_DUMMY = 7'h08,
        ST_DIN = 7'h10, ST_DOUT = 7'h20, ST_SKIP = 7'h40
    } sff_state_type;

    function automatic logic sff_is_quad(input logic [7:0] c);
        return c == CMD_QOUT || c == CMD_QIO || c == CMD_QWORD || c == CMD_QOCT;
    endfunction

    function automatic logic sff_is_alter(input logic [7:0] c);
        return c == CMD_PROG || c == CMD_SE || c == CMD_BE32 || c == CMD_BE64 || c == CMD_CE1
            || c == CMD_CE2 || c == CMD_WRSR;
    endfunction

    function automatic logic [2:0] sff_addr_lanes(input logic [7:0] c);
        if (c == CMD_DIO2)
            return 3'h2;
        return (c == CMD_QIO || c == CMD_QWORD || c == CMD_QOCT) ? 3'h4 : 3'h1;
    endfunction

    function automatic logic [2:0] sff_data_lanes(input logic [7:0] c);
        if (c == CMD_DOUT2 || c == CMD_DIO2)
            return 3'h2;
        return sff_is_quad(c) ? 3'h4 : 3'h1;
    endfunction

    // Dummy clocks include the mode bits of the wide address forms.
    function automatic logic [4:0] sff_dummy(input logic [7:0] c);
        case (c)
            CMD_FREAD, CMD_DOUT2, CMD_QOUT: return 5'h08;
            CMD_DIO2, CMD_QWORD: return 5'h04;
            CMD_QIO: return 5'h06;
            CMD_QOCT: return 5'h02;
            default: return 5'h00;
        endcase
    endfunction

    function automatic sff_state_type sff_after_cmd(input logic [7:0] c);
        case (c)
            CMD_RDSR1, CMD_RDSR2: return ST_DOUT;
            CMD_READ, CMD_FREAD, CMD_DOUT2, CMD_DIO2, CMD_QOUT, CMD_QIO, CMD_QWORD, CMD_QOCT,
            CMD_PROG, CMD_SE, CMD_BE32, CMD_BE64: return ST_ADDR;
            CMD_WREN, CMD_WRDI, CMD_WRSR, CMD_CE1, CMD_CE2, CMD_PDOWN, CMD_PDREL,
            CMD_SUSP: return ST_DIN;
            default: return ST_SKIP;
        endcase
    endfunction

    function automatic logic sff_guarded(input logic [19:0] a, input logic [15:0] s);
        logic [2:0] bp;
        logic [20:0] size;
        logic hit;
        bp = s[SB_RG_LO +: 3];
        if (bp == 3'h0)
            size = 21'h0;
        else if (!s[SB_SMALL])
            size = (bp > 3'h4) ? ARRAY_SIZE : (BLOCK_SIZE << (bp - 3'h1));
        else
            size = (bp[2:1] == 2'h3) ? ARRAY_SIZE : (bp[2] ? SMALL_MAX : (SECTOR_SIZE << (bp - 3'h1)));
        hit = s[SB_LOWEND] ? ({1'b0, a} < size) : ({1'b0, a} >= (ARRAY_SIZE - size));
        return hit ^ s[SB_INV];
    endfunction
endpackage

// ==== sff_sync.sv ====
`timescale 1ns/1ps
module sff_sync
    import sff_pkg::*;
#(
    parameter int W = 6
)
(
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // Pins in, clean levels out
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_reg;
    logic [W-1:0] sync_reg;

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            meta_reg <= '0;
            sync_reg <= '0;
        end
        else
        begin
            meta_reg <= d;
            sync_reg <= meta_reg;
        end
    end

    assign q = sync_reg;
endmodule // sff_sync
